// ==== bench/prog_mem.sv ====
// Program memory model: one 14-bit word per address, answered combinationally.
// Assumes the bench loads the words array before it lets the core run.
`timescale 1ns/100ps
`default_nettype none
module prog_mem (
  input wire logic [insn_decoder_pkg::PC_W-1:0] prog_addr,
  output logic [insn_decoder_pkg::INSN_W-1:0] prog_word
);
  logic [insn_decoder_pkg::INSN_W-1:0] words [0:31];
  // Fetches past the loaded image see the no-op word, so a runaway core stays harmless.
  assign prog_word = (prog_addr < 13'h0020) ? words[prog_addr[4:0]] :
                     insn_decoder_pkg::NOP_WORD;
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench: small programs run through the decoder, results read over Avalon-MM.
// Assumes the design's register map and its read answer after one wait state.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk;
  logic rst_n;
  logic [3:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic [insn_decoder_pkg::PC_W-1:0] prog_addr;
  logic [insn_decoder_pkg::INSN_W-1:0] prog_word;
  logic [7:0] port_pins;
  logic [7:0] port_latch;
  logic prescaler_on_timer0;
  logic prescaler_clear;
  logic watch_timer_clear;
  int num_errors = 0;
  int total_checks = 0;
  int num_pre = 0;
  int num_watch = 0;
  logic [13:0] prog [$];
  logic [31:0] q;

  midrange_insn_decoder dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .prog_addr(prog_addr), .prog_word(prog_word), .port_pins(port_pins),
    .port_latch(port_latch), .prescaler_on_timer0(prescaler_on_timer0),
    .prescaler_clear(prescaler_clear), .watch_timer_clear(watch_timer_clear));
  prog_mem pm (.prog_addr(prog_addr), .prog_word(prog_word));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (prescaler_clear === 1'b1) num_pre++;
    if (watch_timer_clear === 1'b1) num_watch++;
  end

  task report_and_stop;
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // One bus cycle; the request is held until waitrequest is seen low at a rising edge.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 50)
    begin
      num_errors++;
      report_and_stop();
    end
  endtask

  // Loads prog, resets the core, runs it until standby, then compares W and the flags.
  task run_prog(input logic [7:0] exp_w, input logic [7:0] exp_f);
    int i;
    for (i = 0; i < 32; i++)
      pm.words[i] = (i < prog.size()) ? prog[i] : insn_decoder_pkg::NOP_WORD;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    num_pre = 0;
    num_watch = 0;
    bus(1'b0, insn_decoder_pkg::REG_FLAGS, 32'h0, q);
    check("reset flags", 32'h00000018, q);
    bus(1'b0, insn_decoder_pkg::REG_PC, 32'h0, q);
    check("reset pc", 32'h00000000, q);
    bus(1'b1, insn_decoder_pkg::REG_CTRL, 32'h00000001, q);
    expect_halt(exp_w, exp_f);
  endtask

  // Polls until the core reports standby, then compares the accumulator and the flags.
  task expect_halt(input logic [7:0] exp_w, input logic [7:0] exp_f);
    int i;
    for (i = 0; i < 200; i++)
    begin
      bus(1'b0, insn_decoder_pkg::REG_FLAGS, 32'h0, q);
      if (q[5] === 1'b1) break;
    end
    if (i == 200)
    begin
      num_errors++;
      report_and_stop();
    end
    check("flags", {24'h0, exp_f}, q);
    bus(1'b0, insn_decoder_pkg::REG_ACC, 32'h0, q);
    check("accumulator", {24'h0, exp_w}, q);
  endtask

  initial
  begin
    rst_n = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    port_pins = 8'hA5;
    prescaler_on_timer0 = 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // Decrement to zero with W destination skips and leaves Z alone.
    prog = {14'h3001, 14'h00FF, 14'h0B7F, 14'h3055, 14'h0063};
    run_prog(8'h00, 8'h30);
    // Increment wraps to zero in the file and skips the next move.
    prog = {14'h30FF, 14'h00A0, 14'h0FA0, 14'h3011, 14'h0420, 14'h0063};
    run_prog(8'hFF, 8'h30);
    prog = {14'h305A, 14'h00A1, 14'h0621, 14'h0063};
    run_prog(8'h00, 8'h34);
    prog = {14'h3081, 14'h00A2, 14'h0D22, 14'h0CA2, 14'h0822, 14'h0063};
    run_prog(8'hC0, 8'h31);
    // Don't-care bits set in a no-op and a literal move.
    prog = {14'h3010, 14'h00A3, 14'h1E23, 14'h3301, 14'h0060, 14'h1A23, 14'h3333, 14'h0063};
    run_prog(8'h33, 8'h30);
    // Call into a literal return; the word after the return must never execute.
    prog = {14'h2004, 14'h3C03, 14'h3840, 14'h0063, 14'h3403, 14'h30EE};
    run_prog(8'h40, 8'h33);
    prog = {14'h30FF, 14'h0086, 14'h0986, 14'h0081, 14'h0064, 14'h0063};
    run_prog(8'hFF, 8'h30);
    check("port latch", 32'h0000005A, {24'h0, port_latch});
    check("prescaler clears", 32'h1, num_pre);
    check("watch clears", 32'h2, num_watch);
    // Unknown literal-class word runs as a one-cycle no-op.
    prog = {14'h3007, 14'h3B12, 14'h0063};
    run_prog(8'h07, 8'h30);
    // The accumulator is read-only from the bus, and unmapped places read zero.
    bus(1'b1, insn_decoder_pkg::REG_ACC, 32'h000000AA, q);
    bus(1'b0, insn_decoder_pkg::REG_ACC, 32'h0, q);
    check("acc after bus write", 32'h00000007, q);
    bus(1'b0, 4'h2, 32'h0, q);
    check("unmapped read", 32'h00000000, q);
    // Standby, then wake: the word after the standby word must run next, and a timer
    // write while the prescaler belongs elsewhere must leave the prescaler alone.
    prescaler_on_timer0 <= 1'b0;
    prog = {14'h300F, 14'h00A4, 14'h0EA4, 14'h0524, 14'h2806, 14'h30EE, 14'h0063,
            14'h0AA4, 14'h0224, 14'h39F0, 14'h3AF0, 14'h0103, 14'h0081, 14'h0063};
    run_prog(8'h00, 8'h34);
    bus(1'b1, insn_decoder_pkg::REG_CTRL, 32'h00000003, q);
    expect_halt(8'h00, 8'h37);
    check("prescaler clears off", 32'h0, num_pre);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== hdl/insn_decoder_pkg.sv ====
// Constants for the 14-bit instruction decoder and its register port.
// Assumes one 40 MHz clock; four clocks stand for one oscillator-derived quarter cycle each.
package insn_decoder_pkg;
  localparam int INSN_W = 14;
  localparam int PC_W = 13;
  localparam int FILE_DEPTH = 128;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [INSN_W-1:0] NOP_WORD = 14'h0000;
  // Instruction classes, taken from the two top bits.
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  // Byte-oriented sub-opcodes.
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_IOR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOV = 4'h8;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_INC = 4'hA;
  localparam logic [3:0] OP_DECSKIP = 4'hB;
  localparam logic [3:0] OP_RRC = 4'hC;
  localparam logic [3:0] OP_RLC = 4'hD;
  localparam logic [3:0] OP_SWAP = 4'hE;
  localparam logic [3:0] OP_INCSKIP = 4'hF;
  // Low byte of control words in the misc group.
  localparam logic [7:0] CTL_RETURN = 8'h08;
  localparam logic [7:0] CTL_RETINT = 8'h09;
  localparam logic [7:0] CTL_STANDBY = 8'h63;
  localparam logic [7:0] CTL_CLRWATCH = 8'h64;
  localparam logic [7:0] NOP_MASK = 8'h9F;
  // Bit-oriented sub-opcodes.
  localparam logic [1:0] BOP_CLR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_SKIPCLR = 2'h2;
  localparam logic [1:0] BOP_SKIPSET = 2'h3;
  // Special file addresses.
  localparam logic [6:0] PORT_ADDR = 7'h06;
  localparam logic [6:0] TIMER0_ADDR = 7'h01;
  // Register port byte addresses.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FLAGS = 4'h4;
  localparam logic [3:0] REG_ACC = 4'h8;
  localparam logic [3:0] REG_PC = 4'hC;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_WAKE = 1;
  typedef enum logic {st_active, st_standby} run_state_type;
endpackage

// ==== hdl/midrange_insn_decoder.sv ====
// Decoder and sequencer for a 14-bit instruction word, with its file, accumulator and stack.
// Program memory answers combinationally on the same clock; software uses Avalon-MM.
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module midrange_insn_decoder #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [insn_decoder_pkg::PC_W-1:0] prog_addr,
  input wire logic [insn_decoder_pkg::INSN_W-1:0] prog_word,
  input wire logic [7:0] port_pins,
  output logic [7:0] port_latch,
  input wire logic prescaler_on_timer0,
  output logic prescaler_clear,
  output logic watch_timer_clear
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  logic [1:0] phase;
  logic run_enable;
  insn_decoder_pkg::run_state_type state;
  logic [insn_decoder_pkg::INSN_W-1:0] insn;
  logic flush;
  logic [insn_decoder_pkg::PC_W-1:0] program_counter_reg;
  logic [7:0] w_reg;
  logic carry_flag;
  logic digit_carry_flag;
  logic zero_flag;
  logic timeout_status_bit;
  logic powerdown_status_bit;
  logic [7:0] file_mem [insn_decoder_pkg::FILE_DEPTH];
  logic [insn_decoder_pkg::PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [SP_W-1:0] sp;
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic [7:0] pin_s3;
  logic [7:0] pin_level;
  logic rd_done;

  // Add with carry in; returns {carry, digit carry, sum}.
  function automatic logic [9:0] add_full(input logic [7:0] a, input logic [7:0] b,
                                          input logic ci);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction

  wire [1:0] cls = insn[13:12];
  wire [3:0] sub = insn[11:8];
  wire dsel = insn[7];
  wire [6:0] fsel = insn[6:0];
  wire [2:0] bsel = insn[9:7];
  wire [1:0] bop = insn[11:10];
  wire [7:0] lit = insn[7:0];
  wire [10:0] k11 = insn[10:0];
  wire [insn_decoder_pkg::PC_W-1:0] stack_top = stack_mem[sp - SP_W'(1)];
  wire [insn_decoder_pkg::PC_W-1:0] pc_inc = program_counter_reg + 13'h0001;
  // Port reads always see the pins, so a read-modify-write writes back pin levels.
  wire [7:0] opnd = (fsel == insn_decoder_pkg::PORT_ADDR) ? pin_level : file_mem[fsel];
  wire exec_now = (phase == insn_decoder_pkg::PHASE_LAST) && run_enable &&
                  (state == insn_decoder_pkg::st_active);
  wire do_insn = exec_now && !flush;
  wire bit_val = opnd[bsel];
  wire [9:0] add_wf = add_full(opnd, w_reg, 1'b0);
  wire [9:0] sub_wf = add_full(opnd, ~w_reg, 1'b1);
  wire [9:0] add_wl = add_full(lit, w_reg, 1'b0);
  wire [9:0] sub_wl = add_full(lit, ~w_reg, 1'b1);

  logic [7:0] res;
  logic use_dest;
  logic wr_w;
  logic upd_c;
  logic upd_dc;
  logic upd_z;
  logic new_c;
  logic new_dc;
  logic skip;
  logic jump;
  logic [insn_decoder_pkg::PC_W-1:0] target;
  logic push;
  logic pop;
  logic go_sleep;
  logic kick_watch;
  logic bit_write;

  always_comb
  begin
    res = opnd;
    use_dest = 1'b0;
    wr_w = 1'b0;
    bit_write = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    new_c = carry_flag;
    new_dc = digit_carry_flag;
    skip = 1'b0;
    jump = 1'b0;
    target = pc_inc;
    push = 1'b0;
    pop = 1'b0;
    go_sleep = 1'b0;
    kick_watch = 1'b0;
    case (cls)
      insn_decoder_pkg::CLS_BYTE:
      begin
        use_dest = 1'b1;
        upd_z = 1'b1;
        case (sub)
          insn_decoder_pkg::OP_MISC:
          begin
            use_dest = 1'b0;
            upd_z = 1'b0;
            res = w_reg;
            if (dsel)
              bit_write = 1'b1;
            else if (lit == insn_decoder_pkg::CTL_RETURN ||
                     lit == insn_decoder_pkg::CTL_RETINT)
            begin
              jump = 1'b1;
              pop = 1'b1;
              target = stack_top;
            end
            else if (lit == insn_decoder_pkg::CTL_STANDBY)
              go_sleep = 1'b1;
            else if (lit == insn_decoder_pkg::CTL_CLRWATCH)
              kick_watch = 1'b1;
            // Every other word here, the plain no-op included, does nothing.
          end
          insn_decoder_pkg::OP_CLR: res = 8'h00;
          insn_decoder_pkg::OP_SUB:
          begin
            {new_c, new_dc, res} = sub_wf;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          insn_decoder_pkg::OP_DEC: res = opnd - 8'h01;
          insn_decoder_pkg::OP_IOR: res = opnd | w_reg;
          insn_decoder_pkg::OP_AND: res = opnd & w_reg;
          insn_decoder_pkg::OP_XOR: res = opnd ^ w_reg;
          insn_decoder_pkg::OP_ADD:
          begin
            {new_c, new_dc, res} = add_wf;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          insn_decoder_pkg::OP_MOV: res = opnd;
          insn_decoder_pkg::OP_COM: res = ~opnd;
          insn_decoder_pkg::OP_INC: res = opnd + 8'h01;
          insn_decoder_pkg::OP_DECSKIP:
          begin
            res = opnd - 8'h01;
            upd_z = 1'b0;
            skip = (res == 8'h00);
          end
          insn_decoder_pkg::OP_INCSKIP:
          begin
            res = opnd + 8'h01;
            upd_z = 1'b0;
            skip = (res == 8'h00);
          end
          insn_decoder_pkg::OP_RRC:
          begin
            {res, new_c} = {carry_flag, opnd};
            upd_z = 1'b0;
            upd_c = 1'b1;
          end
          insn_decoder_pkg::OP_RLC:
          begin
            {new_c, res} = {opnd, carry_flag};
            upd_z = 1'b0;
            upd_c = 1'b1;
          end
          insn_decoder_pkg::OP_SWAP:
          begin
            res = {opnd[3:0], opnd[7:4]};
            upd_z = 1'b0;
          end
          default: res = opnd;
        endcase
        // The clear group with d clear is the accumulator clear.
        wr_w = use_dest && !dsel;
      end
      insn_decoder_pkg::CLS_BIT:
      begin
        case (bop)
          insn_decoder_pkg::BOP_CLR:
          begin
            res[bsel] = 1'b0;
            bit_write = 1'b1;
          end
          insn_decoder_pkg::BOP_SET:
          begin
            res[bsel] = 1'b1;
            bit_write = 1'b1;
          end
          insn_decoder_pkg::BOP_SKIPCLR: skip = !bit_val;
          insn_decoder_pkg::BOP_SKIPSET: skip = bit_val;
          default: skip = 1'b0;
        endcase
      end
      insn_decoder_pkg::CLS_JUMP:
      begin
        jump = 1'b1;
        push = !insn[11];
        target = {program_counter_reg[12:11], k11};
      end
      insn_decoder_pkg::CLS_LIT:
      begin
        wr_w = 1'b1;
        upd_z = 1'b1;
        casez (sub)
          4'b00??:
          begin
            res = lit;
            upd_z = 1'b0;
          end
          4'b01??:
          begin
            res = lit;
            upd_z = 1'b0;
            jump = 1'b1;
            pop = 1'b1;
            target = stack_top;
          end
          4'b1000: res = lit | w_reg;
          4'b1001: res = lit & w_reg;
          4'b1010: res = lit ^ w_reg;
          4'b110?:
          begin
            {new_c, new_dc, res} = sub_wl;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          4'b111?:
          begin
            {new_c, new_dc, res} = add_wl;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          default:
          begin
            wr_w = 1'b0;
            upd_z = 1'b0;
          end
        endcase
      end
      default: res = opnd;
    endcase
  end

  wire wr_f = (use_dest && dsel) || bit_write;
  wire file_write = do_insn && wr_f;
  wire next_flush = do_insn && (skip || jump);
  wire flags_hit = (address == insn_decoder_pkg::REG_FLAGS);
  wire [31:0] read_mux =
    (address == insn_decoder_pkg::REG_CTRL) ? {31'h0, run_enable} :
    flags_hit ? {26'h0, state == insn_decoder_pkg::st_standby, timeout_status_bit,
                 powerdown_status_bit, zero_flag, digit_carry_flag, carry_flag} :
    (address == insn_decoder_pkg::REG_ACC) ? {24'h0, w_reg} :
    (address == insn_decoder_pkg::REG_PC) ? {19'h0, program_counter_reg} : 32'h0;
  wire ctrl_write = write && (address == insn_decoder_pkg::REG_CTRL);

  assign waitrequest = read && !rd_done;
  assign prog_addr = program_counter_reg;

  // Quarter-cycle counter: four clocks make one instruction cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
  end

  // Reads take one wait state so read data come from a flop.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_done <= 1'b0;
      readdata <= 32'h0;
      run_enable <= 1'b0;
    end
    else
    begin
      rd_done <= read && !rd_done;
      if (read && !rd_done)
        readdata <= read_mux;
      if (ctrl_write)
        run_enable <= writedata[insn_decoder_pkg::CTRL_RUN];
    end
  end

  // Pins come from outside; the first stage feeds only the second.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
      pin_s3 <= 8'h00;
      pin_level <= 8'h00;
    end
    else
    begin
      pin_s1 <= port_pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3)
        pin_level <= pin_s3;
    end
  end

  // Fetch and sequence: the fetched word is discarded when flush is set.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      insn <= insn_decoder_pkg::NOP_WORD;
      flush <= 1'b0;
      program_counter_reg <= '0;
      state <= insn_decoder_pkg::st_active;
      sp <= '0;
    end
    else
    begin
      case (state)
        insn_decoder_pkg::st_active:
          if (exec_now)
          begin
            flush <= next_flush;
            // The word after the standby word is fetched now, so it runs first after wake
            // instead of the standby word sending the core straight back to sleep.
            if (do_insn && go_sleep)
              state <= insn_decoder_pkg::st_standby;
            insn <= prog_word;
            program_counter_reg <= (do_insn && jump) ? target : pc_inc;
            if (do_insn && push)
              sp <= sp + SP_W'(1);
            else if (do_insn && pop)
              sp <= sp - SP_W'(1);
          end
        insn_decoder_pkg::st_standby:
          if (ctrl_write && writedata[insn_decoder_pkg::CTRL_WAKE])
            state <= insn_decoder_pkg::st_active;
        default: state <= insn_decoder_pkg::st_active;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (do_insn && push)
      stack_mem[sp] <= program_counter_reg;
    if (file_write && fsel != insn_decoder_pkg::PORT_ADDR)
      file_mem[fsel] <= res;
  end

  // Accumulator, status flags and side-effect pulses.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_reg <= 8'h00;
      carry_flag <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      timeout_status_bit <= 1'b1;
      powerdown_status_bit <= 1'b1;
      port_latch <= 8'h00;
      prescaler_clear <= 1'b0;
      watch_timer_clear <= 1'b0;
    end
    else
    begin
      prescaler_clear <= file_write && (fsel == insn_decoder_pkg::TIMER0_ADDR) &&
                         prescaler_on_timer0;
      watch_timer_clear <= do_insn && (kick_watch || go_sleep);
      if (file_write && fsel == insn_decoder_pkg::PORT_ADDR)
        port_latch <= res;
      if (do_insn)
      begin
        if (wr_w)
          w_reg <= res;
        if (upd_c)
          carry_flag <= new_c;
        if (upd_dc)
          digit_carry_flag <= new_dc;
        if (upd_z)
          zero_flag <= (res == 8'h00);
        if (go_sleep || kick_watch)
        begin
          timeout_status_bit <= 1'b1;
          powerdown_status_bit <= !go_sleep;
        end
      end
    end
  end

  a_phase_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == 2'h0) |-> ##3 (phase == 2'h3) ##1 (phase == 2'h0))
    else $error("instruction cycle is not four clocks");
  a_skip_flush: assert property (@(posedge clk) disable iff (!rst_n)
    (do_insn && (skip || jump)) |=> flush)
    else $error("skip or jump did not flush the next word");
  a_flush_is_nop: assert property (@(posedge clk) disable iff (!rst_n)
    (exec_now && flush) |=> (!flush && $stable(w_reg) && $stable(zero_flag)))
    else $error("flushed word was executed");
  a_decskip_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (do_insn && cls == insn_decoder_pkg::CLS_BYTE && sub == insn_decoder_pkg::OP_DECSKIP)
    |=> ($stable(zero_flag) && $stable(carry_flag) && $stable(digit_carry_flag)))
    else $error("decrement-skip changed a flag");
  a_incskip_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (do_insn && cls == insn_decoder_pkg::CLS_BYTE && sub == insn_decoder_pkg::OP_INCSKIP)
    |=> ($stable(zero_flag) && $stable(carry_flag) && $stable(digit_carry_flag)))
    else $error("increment-skip changed a flag");
  a_or_zero_only: assert property (@(posedge clk) disable iff (!rst_n)
    (do_insn && cls == insn_decoder_pkg::CLS_BYTE && sub == insn_decoder_pkg::OP_IOR)
    |=> ($stable(carry_flag) && (zero_flag == ($past(res) == 8'h00))))
    else $error("file OR flag update wrong");
  a_rotate_carry: assert property (@(posedge clk) disable iff (!rst_n)
    (do_insn && cls == insn_decoder_pkg::CLS_BYTE && sub == insn_decoder_pkg::OP_RLC)
    |=> ($stable(zero_flag) && carry_flag == $past(opnd[7])))
    else $error("rotate left carry wrong");
  a_return_lit: assert property (@(posedge clk) disable iff (!rst_n)
    (do_insn && cls == insn_decoder_pkg::CLS_LIT && sub[3:2] == 2'h1)
    |=> (program_counter_reg == $past(stack_top) && w_reg == $past(lit) && flush))
    else $error("return with literal wrong");
  a_standby_bits: assert property (@(posedge clk) disable iff (!rst_n)
    (do_insn && go_sleep) |=> (timeout_status_bit && !powerdown_status_bit &&
    state == insn_decoder_pkg::st_standby))
    else $error("standby status bits wrong");
  a_timer_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (file_write && fsel == insn_decoder_pkg::TIMER0_ADDR && prescaler_on_timer0)
    |=> prescaler_clear)
    else $error("timer write missed prescaler clear");
endmodule
`default_nettype wire
